// >>> vic_pkg.sv
// Package of constants for the vectored interrupt controller
package vic_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [3:0] OFS_IRQ_EN     = 4'h0;
    localparam logic [3:0] OFS_PRIO_LOW   = 4'h1;
    localparam logic [3:0] OFS_PRIO_HIGH  = 4'h2;
    localparam logic [3:0] OFS_EXT_CTRL   = 4'h3;
    localparam logic [3:0] OFS_FLAGS      = 4'h4;
    localparam logic [3:0] OFS_MODE       = 4'h5;
    localparam logic [3:0] OFS_STATUS     = 4'h6;
    // ==========================================================
    // Field positions
    localparam int GATE_BIT      = 7;
    localparam int EXT2_EN_BIT   = 2;
    localparam int EXT2_PRIO_BIT = 3;
    localparam int EXT3_EN_BIT   = 6;
    localparam int EXT3_PRIO_BIT = 7;
    localparam int EXT0_TRIG_BIT = 0;
    localparam int EXT1_TRIG_BIT = 1;
    // Flag register layout
    localparam int FL_EXT0 = 0;
    localparam int FL_TMR0 = 1;
    localparam int FL_EXT1 = 2;
    localparam int FL_TMR1 = 3;
    localparam int FL_URX  = 4;
    localparam int FL_UTX  = 5;
    localparam int FL_T2OV = 6;
    localparam int FL_T2EX = 7;
    localparam int FL_EXT2 = 8;
    localparam int FL_EXT3 = 9;
    // ==========================================================
    // Reset values, vectors, source count and clocks per machine cycle
    localparam logic [7:0]  RST_REG     = 8'h00;
    localparam logic [15:0] VEC_BASE    = 16'h0003;
    localparam logic [15:0] VEC_STRIDE  = 16'h0008;
    localparam int          NUM_SRC     = 8;
    localparam int          CLK_PER_MC  = 12;
endpackage : vic_pkg

// >>> vic_core.sv
// Vectored interrupt controller with four priority levels and eight sources
`timescale 1ns/100ps
module vic_core #(
    parameter int MC_CLKS = vic_pkg::CLK_PER_MC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // External interrupt pins, active low
    input  wire logic        ext_irq_pin_0,
    input  wire logic        ext_irq_pin_1,
    input  wire logic        ext_irq_pin_2,
    input  wire logic        ext_irq_pin_3,
    // Peripheral set pulses
    input  wire logic        tmr0_ovf_set,
    input  wire logic        tmr1_ovf_set,
    input  wire logic        tmr2_ovf_set,
    input  wire logic        tmr2_ext_set,
    input  wire logic        uart_rx_set,
    input  wire logic        uart_tx_set,
    // CPU handshake
    input  wire logic        instr_last_cycle,
    input  wire logic        instr_blocks_irq,
    input  wire logic        isr_exit_op,
    input  wire logic        sub_exit_op,
    input  wire logic        power_down,
    input  wire logic [15:0] cpu_pc,
    // Vector call outputs
    output logic             vector_call,
    output logic      [15:0] vector_addr,
    output logic      [15:0] push_pc,
    output logic             pop_pc,
    output logic             wake_req,
    output logic      [3:0]  in_service
);
    // ==========================================================
    // Registers
    logic [7:0] irq_en_reg;
    logic [7:0] prio_low_reg;
    logic [7:0] prio_high_reg;
    logic [7:0] ext_irq_ctrl_reg;
    logic [1:0] trig_sel;
    logic       ext0_flag, ext1_flag, ext2_flag, ext3_flag;
    logic       tmr0_ovf_flag, tmr1_ovf_flag, tmr2_ovf_flag, tmr2_ext_flag;
    logic       uart_rx_flag, uart_tx_flag;
    logic [3:0] pin_smp;
    logic [3:0] pin_prev;
    logic [7:0] mc_cnt;
    logic       mc_tick;
    logic [7:0] req;
    logic [7:0] en;
    logic [1:0] lvl [vic_pkg::NUM_SRC];
    logic       win_valid;
    logic [2:0] win_idx;
    logic [1:0] win_lvl;
    logic       take;
    logic [3:0] ext_edge;
    logic       ext0_trig_sel, ext1_trig_sel;
    logic       global_irq_gate;
    logic       wr_fl;
    logic [15:0] flags_vec;

    assign ext0_trig_sel   = trig_sel[vic_pkg::EXT0_TRIG_BIT];
    assign ext1_trig_sel   = trig_sel[vic_pkg::EXT1_TRIG_BIT];
    assign global_irq_gate = irq_en_reg[vic_pkg::GATE_BIT];
    assign wr_fl           = reg_wr && (reg_addr == vic_pkg::OFS_FLAGS);

    // ==========================================================
    // Machine cycle timing
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mc_cnt <= 8'h00;
        end else if (mc_cnt == 8'(MC_CLKS - 1)) begin
            mc_cnt <= 8'h00;
        end else begin
            mc_cnt <= mc_cnt + 8'h01;
        end
    end
    assign mc_tick = (mc_cnt == 8'(MC_CLKS - 1));

    // Pin sampling once per machine cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_smp  <= 4'hf;
            pin_prev <= 4'hf;
        end else if (mc_tick) begin
            pin_prev <= pin_smp;
            pin_smp  <= {ext_irq_pin_3, ext_irq_pin_2, ext_irq_pin_1, ext_irq_pin_0};
        end
    end
    // High in one sample, low in the next; flagged one tick after the sample
    assign ext_edge = pin_prev & ~pin_smp;

    // ==========================================================
    // Configuration registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_en_reg       <= vic_pkg::RST_REG;
            prio_low_reg     <= vic_pkg::RST_REG;
            prio_high_reg    <= vic_pkg::RST_REG;
            ext_irq_ctrl_reg <= vic_pkg::RST_REG;
            trig_sel         <= 2'h0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                vic_pkg::OFS_IRQ_EN:    irq_en_reg       <= reg_wdata[7:0];
                vic_pkg::OFS_PRIO_LOW:  prio_low_reg     <= reg_wdata[7:0];
                vic_pkg::OFS_PRIO_HIGH: prio_high_reg    <= reg_wdata[7:0];
                vic_pkg::OFS_EXT_CTRL:  ext_irq_ctrl_reg <= reg_wdata[7:0];
                vic_pkg::OFS_MODE:      trig_sel         <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Request flags; hardware set wins over any clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ext0_flag <= 1'b0;
            ext1_flag <= 1'b0;
            ext2_flag <= 1'b0;
            ext3_flag <= 1'b0;
        end else begin
            // Edge mode latches, level mode tracks the sampled pin
            if (!ext0_trig_sel) begin
                ext0_flag <= ~pin_smp[0] | (wr_fl & reg_wdata[vic_pkg::FL_EXT0]);
            end else if (mc_tick && ext_edge[0]) begin
                ext0_flag <= 1'b1;
            end else if (wr_fl) begin
                ext0_flag <= reg_wdata[vic_pkg::FL_EXT0];
            end else if (take && win_idx == 3'h0) begin
                ext0_flag <= 1'b0;
            end
            if (!ext1_trig_sel) begin
                ext1_flag <= ~pin_smp[1] | (wr_fl & reg_wdata[vic_pkg::FL_EXT1]);
            end else if (mc_tick && ext_edge[1]) begin
                ext1_flag <= 1'b1;
            end else if (wr_fl) begin
                ext1_flag <= reg_wdata[vic_pkg::FL_EXT1];
            end else if (take && win_idx == 3'h2) begin
                ext1_flag <= 1'b0;
            end
            // External 2 and 3 are edge flags that only software clears
            if (mc_tick && ext_edge[2]) begin
                ext2_flag <= 1'b1;
            end else if (wr_fl) begin
                ext2_flag <= reg_wdata[vic_pkg::FL_EXT2];
            end
            if (mc_tick && ext_edge[3]) begin
                ext3_flag <= 1'b1;
            end else if (wr_fl) begin
                ext3_flag <= reg_wdata[vic_pkg::FL_EXT3];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tmr0_ovf_flag <= 1'b0;
            tmr1_ovf_flag <= 1'b0;
            tmr2_ovf_flag <= 1'b0;
            tmr2_ext_flag <= 1'b0;
            uart_rx_flag  <= 1'b0;
            uart_tx_flag  <= 1'b0;
        end else begin
            if (tmr0_ovf_set) begin
                tmr0_ovf_flag <= 1'b1;
            end else if (wr_fl) begin
                tmr0_ovf_flag <= reg_wdata[vic_pkg::FL_TMR0];
            end else if (take && win_idx == 3'h1) begin
                tmr0_ovf_flag <= 1'b0;
            end
            if (tmr1_ovf_set) begin
                tmr1_ovf_flag <= 1'b1;
            end else if (wr_fl) begin
                tmr1_ovf_flag <= reg_wdata[vic_pkg::FL_TMR1];
            end else if (take && win_idx == 3'h3) begin
                tmr1_ovf_flag <= 1'b0;
            end
            // Timer 2 and serial flags: software clears only
            tmr2_ovf_flag <= tmr2_ovf_set | (wr_fl ? reg_wdata[vic_pkg::FL_T2OV] : tmr2_ovf_flag);
            tmr2_ext_flag <= tmr2_ext_set | (wr_fl ? reg_wdata[vic_pkg::FL_T2EX] : tmr2_ext_flag);
            uart_rx_flag  <= uart_rx_set | (wr_fl ? reg_wdata[vic_pkg::FL_URX] : uart_rx_flag);
            uart_tx_flag  <= uart_tx_set | (wr_fl ? reg_wdata[vic_pkg::FL_UTX] : uart_tx_flag);
        end
    end

    // ==========================================================
    // Requests, enables and levels
    assign req = {ext3_flag, ext2_flag, tmr2_ovf_flag | tmr2_ext_flag,
                  uart_rx_flag | uart_tx_flag, tmr1_ovf_flag, ext1_flag,
                  tmr0_ovf_flag, ext0_flag};
    assign en = {ext_irq_ctrl_reg[vic_pkg::EXT3_EN_BIT], ext_irq_ctrl_reg[vic_pkg::EXT2_EN_BIT],
                 irq_en_reg[5:0]} & {8{global_irq_gate}};

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            lvl[i] = {prio_high_reg[i], prio_low_reg[i]};
        end
        lvl[6] = {prio_high_reg[6], ext_irq_ctrl_reg[vic_pkg::EXT2_PRIO_BIT]};
        lvl[7] = {prio_high_reg[7], ext_irq_ctrl_reg[vic_pkg::EXT3_PRIO_BIT]};
    end

    // Highest level wins, lowest index breaks ties
    always_comb begin
        win_valid = 1'b0;
        win_idx   = 3'h0;
        win_lvl   = 2'h0;
        for (int i = 0; i < vic_pkg::NUM_SRC; i++) begin
            if (req[i] && en[i] && (!win_valid || lvl[i] > win_lvl)) begin
                win_valid = 1'b1;
                win_idx   = 3'(i);
                win_lvl   = lvl[i];
            end
        end
    end

    // Polled fresh each machine cycle; nothing is held over
    assign take = mc_tick && win_valid && instr_last_cycle && !instr_blocks_irq
                  && !isr_exit_op && ((in_service >> win_lvl) == 4'h0);

    // ==========================================================
    // In-service tracking
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            in_service <= 4'h0;
        end else if (take) begin
            in_service <= in_service | (4'h1 << win_lvl);
        end else if (isr_exit_op) begin
            if (in_service[3]) in_service[3] <= 1'b0;
            else if (in_service[2]) in_service[2] <= 1'b0;
            else if (in_service[1]) in_service[1] <= 1'b0;
            else in_service[0] <= 1'b0;
        end
    end

    // Vector call and stack control
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vector_call <= 1'b0;
            vector_addr <= 16'h0000;
            push_pc     <= 16'h0000;
            pop_pc      <= 1'b0;
        end else begin
            vector_call <= take;
            pop_pc      <= isr_exit_op | sub_exit_op;
            if (take) begin
                vector_addr <= vic_pkg::VEC_BASE + 16'(win_idx) * vic_pkg::VEC_STRIDE;
                push_pc     <= cpu_pc;
            end
        end
    end

    // Power-down wake from enabled external sources only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= power_down && |(en & req & 8'hc5);
        end
    end

    // ==========================================================
    // Register read port
    assign flags_vec = {6'h00, ext3_flag, ext2_flag, tmr2_ext_flag, tmr2_ovf_flag,
                        uart_tx_flag, uart_rx_flag, tmr1_ovf_flag, ext1_flag,
                        tmr0_ovf_flag, ext0_flag};
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                vic_pkg::OFS_IRQ_EN:    reg_rdata <= {8'h00, irq_en_reg};
                vic_pkg::OFS_PRIO_LOW:  reg_rdata <= {8'h00, prio_low_reg};
                vic_pkg::OFS_PRIO_HIGH: reg_rdata <= {8'h00, prio_high_reg};
                vic_pkg::OFS_EXT_CTRL:  reg_rdata <= {8'h00, ext_irq_ctrl_reg};
                vic_pkg::OFS_FLAGS:     reg_rdata <= flags_vec;
                vic_pkg::OFS_MODE:      reg_rdata <= {14'h0000, trig_sel};
                vic_pkg::OFS_STATUS:    reg_rdata <= {8'h00, win_valid, win_lvl, win_idx, 2'h0} | {12'h000, in_service};
                default:                reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule : vic_core

// >>> vic_core_sva.sv
// Concurrent assertions on the interrupt controller ports
`timescale 1ns/100ps
module vic_core_sva #(
    parameter int MC_CLKS = 12
) (
    // Clock, reset and register port
    input wire logic        clk, reset_n, reg_wr, reg_rd,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata, reg_rdata,
    // Pins and peripheral pulses
    input wire logic        ext_irq_pin_0, ext_irq_pin_1, ext_irq_pin_2, ext_irq_pin_3,
    input wire logic        tmr0_ovf_set, tmr1_ovf_set, tmr2_ovf_set, tmr2_ext_set, uart_rx_set, uart_tx_set,
    // CPU side
    input wire logic        instr_last_cycle, instr_blocks_irq, isr_exit_op, sub_exit_op, power_down,
    input wire logic [15:0] cpu_pc, vector_addr, push_pc,
    input wire logic        vector_call, pop_pc, wake_req,
    input wire logic [3:0]  in_service
);
    // ==========================================================
    // Cycles since the last call, saturating
    int gap;
    always_ff @(posedge clk) begin
        if (!reset_n) gap <= MC_CLKS;
        else if (vector_call) gap <= 1;
        else if (gap < MC_CLKS) gap <= gap + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // Properties
    chk_call_pulse: assert property (vector_call |=> !vector_call)
        else $error("call pulse too long");
    chk_vec_table: assert property (vector_call |-> vector_addr[2:0] == 3'h3 && vector_addr[15:6] == 10'h000)
        else $error("vector outside table");
    chk_push_pc: assert property (vector_call |-> push_pc == $past(cpu_pc))
        else $error("pushed pc wrong");
    chk_call_cond: assert property (vector_call |->
        $past(instr_last_cycle) && !$past(instr_blocks_irq) && !$past(isr_exit_op))
        else $error("call taken while barred");
    chk_preempt_level: assert property (vector_call |-> {1'b0, in_service} > {$past(in_service), 1'b0})
        else $error("call not above levels in service");
    chk_service_set: assert property ((in_service & ~$past(in_service)) != 4'h0 |-> vector_call)
        else $error("service bit set without call");
    chk_exit_clear: assert property (isr_exit_op && in_service != 4'h0 |=> in_service < $past(in_service))
        else $error("interrupt return left service set");
    chk_sub_keep: assert property (sub_exit_op && !isr_exit_op && !instr_last_cycle |=> $stable(in_service))
        else $error("plain return changed service");
    chk_pop_after: assert property ((isr_exit_op || sub_exit_op) |=> pop_pc)
        else $error("no pop after return");
    chk_pop_cause: assert property (pop_pc |-> $past(isr_exit_op) || $past(sub_exit_op))
        else $error("pop without return");
    chk_wake_gate: assert property (wake_req |-> $past(power_down))
        else $error("wake outside power down");
    chk_call_spacing: assert property (vector_call |-> gap >= MC_CLKS)
        else $error("calls closer than a machine cycle");
    cover property (vector_call && in_service == 4'h9);
    cover property (pop_pc && in_service != 4'h0);
    cover property (wake_req);
endmodule : vic_core_sva

bind vic_core vic_core_sva #(.MC_CLKS(MC_CLKS)) vic_core_sva_inst (
    .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_irq_pin_0(ext_irq_pin_0), .ext_irq_pin_1(ext_irq_pin_1),
    .ext_irq_pin_2(ext_irq_pin_2), .ext_irq_pin_3(ext_irq_pin_3), .tmr0_ovf_set(tmr0_ovf_set),
    .tmr1_ovf_set(tmr1_ovf_set), .tmr2_ovf_set(tmr2_ovf_set), .tmr2_ext_set(tmr2_ext_set),
    .uart_rx_set(uart_rx_set), .uart_tx_set(uart_tx_set), .instr_last_cycle(instr_last_cycle),
    .instr_blocks_irq(instr_blocks_irq), .isr_exit_op(isr_exit_op), .sub_exit_op(sub_exit_op),
    .power_down(power_down), .cpu_pc(cpu_pc), .vector_addr(vector_addr), .push_pc(push_pc),
    .vector_call(vector_call), .pop_pc(pop_pc), .wake_req(wake_req), .in_service(in_service));

// >>> vic_cpu_model.sv
// Behavioural CPU core facing the interrupt controller
`timescale 1ns/100ps
module vic_cpu_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Bench control: hold the current instruction open
    input  wire logic        stall,
    // Controller side
    input  wire logic        vector_call,
    input  wire logic [15:0] vector_addr,
    input  wire logic        pop_pc,
    output logic             instr_last_cycle,
    output logic      [15:0] cpu_pc
);
    logic [15:0] stack[$];
    assign instr_last_cycle = !stall;
    always @(posedge clk) begin
        if (!reset_n) begin
            cpu_pc <= 16'h0100;
            stack.delete();
        end else if (vector_call) begin
            stack.push_back(cpu_pc);
            cpu_pc <= vector_addr;
        end else if (pop_pc && stack.size() > 0) begin
            cpu_pc <= stack.pop_back();
        end else begin
            cpu_pc <= cpu_pc + 16'h0001;
        end
    end
endmodule : vic_cpu_model

// >>> tb_top.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
module tb_top;
    localparam int MC = 2;
    logic        clk, reset_n, reg_wr, reg_rd, stall, power_down, isr_exit_op, sub_exit_op;
    logic        instr_blocks_irq, vector_call, pop_pc, wake_req, instr_last_cycle, rd_d;
    logic [3:0]  reg_addr, in_service, pin;
    logic [5:0]  hw_set;
    logic [15:0] reg_wdata, reg_rdata, cpu_pc, vector_addr, push_pc, pc_d, fl;
    logic [15:0] exp_vec[$], exp_rd[$];
    logic [15:0] src_fl[8] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0030, 16'h00c0, 16'h0100, 16'h0200};
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          seed = 32'h9ed546a7;
    int          i;
    vic_core #(.MC_CLKS(MC)) vic_core_inst (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pin_0(pin[0]), .ext_irq_pin_1(pin[1]),
        .ext_irq_pin_2(pin[2]), .ext_irq_pin_3(pin[3]), .tmr0_ovf_set(hw_set[0]), .tmr1_ovf_set(hw_set[1]),
        .tmr2_ovf_set(hw_set[2]), .tmr2_ext_set(hw_set[3]), .uart_rx_set(hw_set[4]), .uart_tx_set(hw_set[5]),
        .instr_last_cycle(instr_last_cycle), .instr_blocks_irq(instr_blocks_irq), .isr_exit_op(isr_exit_op),
        .sub_exit_op(sub_exit_op), .power_down(power_down), .cpu_pc(cpu_pc), .vector_call(vector_call),
        .vector_addr(vector_addr), .push_pc(push_pc), .pop_pc(pop_pc), .wake_req(wake_req),
        .in_service(in_service));
    vic_cpu_model vic_cpu_model_inst (.clk(clk), .reset_n(reset_n), .stall(stall), .vector_call(vector_call),
        .vector_addr(vector_addr), .pop_pc(pop_pc), .instr_last_cycle(instr_last_cycle), .cpu_pc(cpu_pc));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ==========================================================
    // Tasks
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        exp_rd.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask : rd
    task automatic hs(input logic [5:0] v);
        @(posedge clk);
        hw_set <= v;
        @(posedge clk);
        hw_set <= 6'h00;
    endtask : hs
    task automatic ex(input bit sub);
        @(posedge clk);
        if (sub) sub_exit_op <= 1'b1;
        else isr_exit_op <= 1'b1;
        @(posedge clk);
        {isr_exit_op, sub_exit_op} <= 2'b00;
    endtask : ex
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic drain;
        int k;
        for (k = 0; k < 200 && exp_vec.size() > 0; k++) @(posedge clk);
        if (exp_vec.size() > 0) begin
            n_mismatch++;
            $display("[ERR] %0t expected call missing", $time);
            exp_vec.delete();
        end
    endtask : drain
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // ==========================================================
    // Result monitor: calls and read data against the noted queues
    always @(posedge clk) begin
        if (vector_call) begin
            if (exp_vec.size() == 0) cmp(vector_addr, 16'hffff, "unexpected call");
            else cmp(vector_addr, exp_vec.pop_front(), "vector");
            cmp(push_pc, pc_d, "pushed pc");
        end
        if (rd_d) cmp(reg_rdata, exp_rd.pop_front(), "read data");
        pc_d = cpu_pc;
        rd_d = reg_rd;
    end
    // ==========================================================
    // Main sequence
    initial begin
        {reg_wr, reg_rd, stall, power_down, isr_exit_op, sub_exit_op, instr_blocks_irq} = 7'h00;
        {reg_addr, reg_wdata, pin, hw_set, rd_d, pc_d} = {4'h0, 16'h0000, 4'hf, 6'h00, 1'b0, 16'h0000};
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        for (i = 0; i < 8; i++) rd((i == 7) ? 4'hf : i[3:0], 16'h0000);
        i = $random(seed);
        wr(vic_pkg::OFS_PRIO_HIGH, {8'h00, i[7:0]});
        rd(vic_pkg::OFS_PRIO_HIGH, {8'h00, i[7:0]});
        wr(vic_pkg::OFS_PRIO_HIGH, 16'h0000);
        $display("test registers done");
        wr(vic_pkg::OFS_MODE, 16'h0003);
        wr(vic_pkg::OFS_EXT_CTRL, 16'h0044);
        wr(vic_pkg::OFS_IRQ_EN, 16'h00bf);
        stall <= 1'b1;
        wr(vic_pkg::OFS_FLAGS, 16'h0305);
        hs(6'h3f);
        fl = 16'h03ff;
        stall <= 1'b0;
        for (i = 0; i < 8; i++) begin
            exp_vec.push_back(vic_pkg::VEC_BASE + vic_pkg::VEC_STRIDE * 16'(i));
            drain();
            fl = fl & ~src_fl[i];
            if (i >= 4) wr(vic_pkg::OFS_FLAGS, fl);
            ex(1'b0);
        end
        $display("test ranking done");
        wr(vic_pkg::OFS_PRIO_HIGH, 16'h0080);
        wr(vic_pkg::OFS_EXT_CTRL, 16'h00c4);
        hs(6'h01);
        exp_vec.push_back(16'h000b);
        drain();
        wr(vic_pkg::OFS_FLAGS, 16'h0200);
        exp_vec.push_back(16'h003b);
        drain();
        hs(6'h02);
        wr(vic_pkg::OFS_FLAGS, 16'h0008);
        idle(4 * MC);
        ex(1'b0);
        idle(4 * MC);
        exp_vec.push_back(16'h001b);
        ex(1'b0);
        drain();
        stall <= 1'b1;
        ex(1'b1);
        stall <= 1'b0;
        ex(1'b0);
        $display("test nesting done");
        instr_blocks_irq <= 1'b1;
        hs(6'h01);
        idle(4 * MC);
        instr_blocks_irq <= 1'b0;
        exp_vec.push_back(16'h000b);
        drain();
        ex(1'b0);
        stall <= 1'b1;
        wr(vic_pkg::OFS_FLAGS, 16'h0100);
        idle(2 * MC);
        wr(vic_pkg::OFS_FLAGS, 16'h0000);
        stall <= 1'b0;
        idle(4 * MC);
        $display("test call conditions done");
        wr(vic_pkg::OFS_MODE, 16'h0002);
        pin[0] <= 1'b0;
        exp_vec.push_back(16'h0003);
        drain();
        exp_vec.push_back(16'h0003);
        ex(1'b0);
        drain();
        pin[0] <= 1'b1;
        idle(2 * MC);
        ex(1'b0);
        pin[1] <= 1'b0;
        exp_vec.push_back(16'h0013);
        drain();
        pin[1] <= 1'b1;
        ex(1'b0);
        idle(4 * MC);
        $display("test pins done");
        stall <= 1'b1;
        power_down <= 1'b1;
        hs(6'h01 | 6'($random(seed)));
        idle(4 * MC);
        cmp({15'h0000, wake_req}, 16'h0000, "wake");
        {pin[3], pin[2]} <= 2'b00;
        idle(4 * MC);
        cmp({15'h0000, wake_req}, 16'h0001, "wake");
        wr(vic_pkg::OFS_FLAGS, 16'h0000);
        {power_down, pin[3], pin[2]} <= 3'b011;
        idle(3 * MC);
        stall <= 1'b0;
        idle(4 * MC);
        $display("test wake done");
        print_verdict();
    end
    initial begin
        #(5000 * 100);
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule : tb_top
